// ---- tb/dif_host_model.sv ----
// host controller model driving the control pins
`timescale 1ns/1ps
`default_nettype none
module dif_host_model (
    input wire logic clk_in,
    input wire dif_pkg::dif_inputs_t want_in,
    output var dif_pkg::dif_inputs_t pins_out
);
    // pins move on the falling edge, far from the sampling edge
    // tool unlock stays a held level, never a one-shot pulse
    always @(negedge clk_in) pins_out <= want_in;
endmodule
`default_nettype wire

// ---- tb/dif_input_monitor.sv ----
// concurrent checks on the input function logic ports
`timescale 1ns/1ps
`default_nettype none
module dif_input_monitor (
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    input wire dif_pkg::dif_inputs_t PINS_IN,
    input wire logic ALARM_RAISE_IN,
    input wire logic [1:0] TOOL_ASSIGN_IN,
    input wire logic [13:0] TORQUE_LIMIT_IN,
    input wire logic [1:0] TUNE_MODE_IN,
    input wire logic COMM_RESET_IN,
    input wire logic [7:0] SLAVE_ADDR_SET_IN,
    input wire dif_pkg::dif_latches_t LATCH_SET_IN,
    input wire logic ALARM_ACTIVE_OUT,
    input wire logic ALARM_FATAL_OUT,
    input wire dif_pkg::dif_latches_t LATCH_OUT,
    input wire logic TOOL_UNLOCKED_OUT,
    input wire logic [13:0] TORQUE_CAP_OUT,
    input wire logic SPEED_CAP_ON_OUT,
    input wire logic AUTO_TUNE_ON_OUT,
    input wire logic AUTO_TUNE_MONITOR_OUT,
    input wire logic [7:0] SLAVE_ADDR_OUT
);
    // $past reaches back three edges, so wait until it sees only run time
    logic [2:0] up_q;
    logic ok;
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            up_q <= 3'h0;
        end else if (up_q != 3'h4) begin
            up_q <= up_q + 3'h1;
        end
    end
    assign ok = up_q == 3'h4;
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);
    sequence s_fault_rise;
        (ok && !PINS_IN.fault_clear) ##1 PINS_IN.fault_clear;
    endsequence
    sequence s_no_raise;
        !ALARM_RAISE_IN [*3];
    endsequence
    a_fault_edge_clear: assert property (s_fault_rise ##0 s_no_raise |=>
        ALARM_FATAL_OUT || !ALARM_ACTIVE_OUT) else $error("alarm kept");
    a_fatal_stays_set: assert property (ALARM_FATAL_OUT |=>
        ALARM_FATAL_OUT && ALARM_ACTIVE_OUT) else $error("fatal lost");
    a_latch_wipe_all: assert property (ok && $rose(PINS_IN.latch_wipe)
        ##0 (LATCH_SET_IN == '0) [*4] |=> LATCH_OUT == '0)
        else $error("latch not wiped");
    a_tool_unassigned_on: assert property (ok && TOOL_ASSIGN_IN == 2'h0
        && $past(TOOL_ASSIGN_IN, 3) == 2'h0 |-> TOOL_UNLOCKED_OUT)
        else $error("tool locked");
    a_torque_cap_value: assert property (ok
        && $past(TORQUE_LIMIT_IN, 3) == TORQUE_LIMIT_IN |->
        TORQUE_CAP_OUT == (!$past(PINS_IN.torque_cap, 3) ? 14'h0000 :
        (TORQUE_LIMIT_IN > 14'h2710 ? 14'h2710 : TORQUE_LIMIT_IN)))
        else $error("torque cap wrong");
    a_speed_cap_on: assert property (ok |->
        SPEED_CAP_ON_OUT == $past(PINS_IN.velocity_cap, 3))
        else $error("speed cap wrong");
    a_tune_follow_pin: assert property (ok && TUNE_MODE_IN == 2'h1
        && $past(TUNE_MODE_IN, 3) == 2'h1 |->
        AUTO_TUNE_ON_OUT == $past(PINS_IN.auto_tune_enable, 3))
        else $error("tune not following");
    a_tune_always_on: assert property (ok && TUNE_MODE_IN == 2'h2
        && $past(TUNE_MODE_IN, 3) == 2'h2 |-> AUTO_TUNE_MONITOR_OUT)
        else $error("tune monitor off");
    a_addr_follow_sel: assert property (ok && COMM_RESET_IN
        && SLAVE_ADDR_SET_IN == 8'hFF && PINS_IN.node_select_bits ==
        $past(PINS_IN.node_select_bits, 3) |=> SLAVE_ADDR_OUT ==
        {4'h0, $past(PINS_IN.node_select_bits)} + 8'h01)
        else $error("address not followed");
    a_addr_zero_kept: assert property (ok && COMM_RESET_IN
        && SLAVE_ADDR_SET_IN == 8'h00 |=> $stable(SLAVE_ADDR_OUT))
        else $error("address zero taken");
endmodule
bind dif_input_logic dif_input_monitor u_mon (.CLK_IN(CLK_IN),
    .RESET_IN(RESET_IN), .PINS_IN(PINS_IN), .ALARM_RAISE_IN(ALARM_RAISE_IN),
    .TOOL_ASSIGN_IN(TOOL_ASSIGN_IN), .TORQUE_LIMIT_IN(TORQUE_LIMIT_IN),
    .TUNE_MODE_IN(TUNE_MODE_IN), .COMM_RESET_IN(COMM_RESET_IN),
    .SLAVE_ADDR_SET_IN(SLAVE_ADDR_SET_IN), .LATCH_SET_IN(LATCH_SET_IN),
    .ALARM_ACTIVE_OUT(ALARM_ACTIVE_OUT), .ALARM_FATAL_OUT(ALARM_FATAL_OUT),
    .LATCH_OUT(LATCH_OUT), .TOOL_UNLOCKED_OUT(TOOL_UNLOCKED_OUT),
    .TORQUE_CAP_OUT(TORQUE_CAP_OUT), .SPEED_CAP_ON_OUT(SPEED_CAP_ON_OUT),
    .AUTO_TUNE_ON_OUT(AUTO_TUNE_ON_OUT), .SLAVE_ADDR_OUT(SLAVE_ADDR_OUT),
    .AUTO_TUNE_MONITOR_OUT(AUTO_TUNE_MONITOR_OUT));
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the input function logic
`timescale 1ns/1ps
`default_nettype none
`include "dif_defines.svh"
module tb_top;
    logic CLK_IN, RESET_IN, ar, af, nr, nac, lac, toe, st, ms, cr;
    logic act, fat, note, exc, tool, son, smode, ploop, ton, tmon;
    dif_pkg::dif_inputs_t w, pins;
    dif_pkg::dif_latches_t lset, lat;
    dif_pkg::dif_state_t ds;
    logic [31:0] ladd, load;
    logic [1:0] ta, em, tm;
    logic [13:0] tl, tcap;
    logic [6:0] sr;
    logic [21:0] sv, sval;
    logic [7:0] sa, ni, saddr, nid;
    int miscompares, n_compared, cycles;
    dif_host_model host (.clk_in(CLK_IN), .want_in(w), .pins_out(pins));
    dif_input_logic DUT (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN),
        .PINS_IN(pins), .ALARM_RAISE_IN(ar), .ALARM_FATAL_IN(af),
        .NOTICE_RAISE_IN(nr), .NOTICE_AUTO_CLEAR_IN(nac),
        .LOAD_AUTO_CLEAR_IN(lac), .LOAD_ADD_IN(ladd), .LATCH_SET_IN(lset),
        .TOOL_ASSIGN_IN(ta), .ETO_MODE_IN(em), .TORQUE_OFF_ENTER_IN(toe),
        .TORQUE_LIMIT_IN(tl), .SPEED_TYPE_IN(st), .SPEED_RATIO_IN(sr),
        .SPEED_VALUE_IN(sv), .MOTOR_STOPPED_IN(ms), .TUNE_MODE_IN(tm),
        .COMM_RESET_IN(cr), .SLAVE_ADDR_SET_IN(sa), .NODE_ID_SET_IN(ni),
        .ALARM_ACTIVE_OUT(act), .ALARM_FATAL_OUT(fat), .NOTICE_OUT(note),
        .LATCH_OUT(lat), .LOAD_OUT(load), .DRIVE_STATE_OUT(ds),
        .EXCITE_OUT(exc), .TOOL_UNLOCKED_OUT(tool), .TORQUE_CAP_OUT(tcap),
        .SPEED_CAP_ON_OUT(son), .SPEED_CAP_MODE_OUT(smode),
        .SPEED_CAP_VAL_OUT(sval), .POS_LOOP_ON_OUT(ploop),
        .AUTO_TUNE_ON_OUT(ton), .AUTO_TUNE_MONITOR_OUT(tmon),
        .SLAVE_ADDR_OUT(saddr), .NODE_ID_OUT(nid));
    initial begin
        CLK_IN = 1'b0;
        forever #25 CLK_IN = ~CLK_IN;
    end
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // the ceiling is several times the whole sequence
    always @(posedge CLK_IN) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            wrap_up;
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge CLK_IN);
    endtask
    task automatic pr(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, e);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic rst;
        RESET_IN = 1'b1;
        // four full rising edges in reset, also for the one at time zero
        repeat (4) @(posedge CLK_IN);
        cyc(1);
        chk("speed default", sval, 22'h32);
        RESET_IN = 1'b0;
        cyc(2);
        chk("slave at start", saddr, 8'h01);
    endtask
    task automatic t_alarm;
        pr(ar);
        w.fault_clear <= 1'h1;
        cyc(6);
        chk("alarm edge", act, 1'h0);
        pr(ar);
        cyc(6);
        chk("alarm held", act, 1'h1);
        w.fault_clear <= 1'h0;
        af = 1'b1;
        pr(ar);
        af = 1'b0;
        cyc(4);
        w.fault_clear <= 1'h1;
        cyc(6);
        chk("alarm fatal", act, 1'h1);
        chk("alarm fatal flag", fat, 1'h1);
        w.fault_clear <= 1'h0;
        rst;
        $display("test alarm done");
    endtask
    task automatic t_eto;
        w.safe_off_a <= 1'h1;
        w.excite_request <= 1'h1;
        pr(toe);
        w.torque_off_release <= 1'h1;
        cyc(6);
        chk("one safe off", ds, dif_pkg::DIF_TORQUE_OFF);
        w.safe_off_b <= 1'h1;
        cyc(6);
        chk("edge held", ds, dif_pkg::DIF_TORQUE_OFF);
        em = `DIF_ETO_LEVEL;
        cyc(6);
        chk("level", ds, dif_pkg::DIF_EXCITED);
        chk("excite", exc, 1'h1);
        em = `DIF_ETO_EDGE;
        w.torque_off_release <= 1'h0;
        pr(toe);
        cyc(4);
        w.torque_off_release <= 1'h1;
        cyc(6);
        chk("edge", ds, dif_pkg::DIF_EXCITED);
        $display("test torque off done");
    endtask
    task automatic t_clear;
        lac = 1'b1;
        ladd = 32'h5;
        lset = '1;
        pr(nr);
        lset = '0;
        ladd = 32'h0;
        w.latch_wipe <= 1'h1;
        w.notice_clear <= 1'h1;
        cyc(6);
        chk("latches", lat, 31'h0);
        chk("load kept", load, 32'h5);
        chk("notice kept", note, 1'h1);
        w.latch_wipe <= 1'h0;
        w.notice_clear <= 1'h0;
        lac = 1'b0;
        nac = 1'b0;
        cyc(4);
        w.latch_wipe <= 1'h1;
        w.notice_clear <= 1'h1;
        cyc(6);
        chk("load wiped", load, 32'h0);
        chk("notice wiped", note, 1'h0);
        $display("test clear done");
    endtask
    task automatic t_tool;
        for (int i = 0; i < 16; i++) begin
            ta = i[3:2];
            w.tool_direct <= i[0];
            w.tool_remote <= i[1];
            cyc(6);
            chk("tool", tool, (!ta[0] || i[0]) && (!ta[1] || i[1]));
        end
        $display("test tool done");
    endtask
    task automatic t_caps;
        w.torque_cap <= 1'h1;
        w.velocity_cap <= 1'h1;
        tl = 14'h3000;
        cyc(6);
        chk("torque clamp", tcap, 14'h2710);
        tl = `DIF_TRQ_RST;
        w.torque_cap <= 1'h0;
        cyc(6);
        chk("torque free", tcap, 14'h0);
        for (int i = 0; i < 4; i++) begin
            st = i[1];
            sr = i[0] ? 7'h78 : 7'h00;
            sv = i[0] ? 22'h3FFFFF : 22'h0;
            cyc(6);
            chk("speed mode", smode, st);
            chk("speed on", son, 1'h1);
            chk("speed", sval, i[0] ? (st ? 22'h3D0900 : 22'h64) : 22'h1);
        end
        $display("test caps done");
    endtask
    task automatic t_loop;
        tm = 2'h1;
        for (int i = 1; i >= 0; i--) begin
            w.hold_loop_select <= i[0];
            w.auto_tune_enable <= i[0];
            cyc(6);
            chk("pos loop", ploop, i[0]);
            chk("tune", ton, i[0]);
        end
        // in motion the loop choice is frozen; mode 0 keeps tuning off
        ms = 1'b0;
        tm = 2'h0;
        w.hold_loop_select <= 1'h1;
        w.auto_tune_enable <= 1'h1;
        cyc(6);
        chk("pos loop moving", ploop, 1'h0);
        chk("tune off", ton, 1'h0);
        ms = 1'b1;
        tm = 2'h2;
        w.auto_tune_enable <= 1'h0;
        cyc(6);
        chk("tune monitor", tmon, 1'h1);
        chk("pos loop stopped", ploop, 1'h1);
        $display("test loop done");
    endtask
    task automatic t_addr;
        logic [7:0] v[3] = '{8'hFF, 8'h1F, 8'h00};
        logic [7:0] es[3] = '{8'h10, 8'h1F, 8'h1F};
        logic [7:0] en[3] = '{8'h10, 8'h7F, 8'h00};
        w.node_select_bits <= 4'hF;
        cyc(4);
        for (int i = 0; i < 3; i++) begin
            sa = v[i];
            ni = (i == 1) ? 8'h7F : v[i];
            pr(cr);
            cyc(2);
            chk("slave", saddr, es[i]);
            chk("node", nid, en[i]);
        end
        $display("test address done");
    endtask
    initial begin
        {ar, af, nr, toe, st, cr, lac, w, lset, ladd, ta, tm} = '0;
        {RESET_IN, nac, ms, em, sa, ni} = {3'h7, `DIF_ETO_EDGE, 16'hFFFF};
        {tl, sr, sv} = {`DIF_TRQ_RST, `DIF_RATIO_RST, `DIF_VEL_RST};
        rst;
        t_alarm;
        t_eto;
        t_clear;
        t_tool;
        t_caps;
        t_loop;
        t_addr;
        wrap_up;
    end
endmodule
`default_nettype wire

// ---- verilog/dif_defines.svh ----
// constants for the driver input function logic
`ifndef DIF_DEFINES_SVH
`define DIF_DEFINES_SVH
`define DIF_ETO_EDGE 2'h1
`define DIF_ETO_LEVEL 2'h2
`define DIF_TRQ_MAX 14'h2710
`define DIF_TRQ_RST 14'h01F4
`define DIF_SPD_RATIO 1'h0
`define DIF_SPD_VALUE 1'h1
`define DIF_RATIO_MIN 7'h01
`define DIF_RATIO_MAX 7'h64
`define DIF_RATIO_RST 7'h32
`define DIF_VEL_MIN 22'h000001
`define DIF_VEL_MAX 22'h3D0900
`define DIF_VEL_RST 22'h0003E8
`define DIF_ADDR_FOLLOW 8'hFF
`define DIF_SLAVE_MAX 8'h1F
`define DIF_NODE_MAX 8'h7F
`define DIF_TORQUE_NONE 14'h0000
`endif

// ---- verilog/dif_input_logic.sv ----
// input signal handling: status release, function change, node address
// Behaviour
// - alarm clears only on OFF-to-ON edge of fault clear input
// - alarms marked non-resettable survive the fault clear edge
// - torque-off release excites motor after both safe-off inputs and request
// - release criterion: code 1 rising edge, code 2 level
// - latch wipe clears user, step, branch latches, event numbers, stop latch
// - latch wipe clears cumulative load only when its auto clear is off
// - notice clear works only while automatic notice clearing is off
// - tool unlock ON releases support-tool limitation, OFF imposes it
// - unassigned tool unlock is ON; both assigned needs both ON
// - torque cap input caps torque at limit, 0 to 10000, default 500
// - velocity cap input limits velocity, ratio or value mode
// - ratio mode limit 1 to 100 percent, default 50
// - value mode limit 1 to 4000000, default 1000
// - when stopped, hold loop select OFF disables, ON enables position loop
// - auto-tune follows enable input when mode says follow input
// - auto-tune monitor ON always when mode says permanently enabled
// - node address is select bits plus one, 1 to 16
// - new address taken at reset and on communication reset command; at reset a -1 setting takes 1, synced select bits still zero
// - serial address -1 follows select bits plus one, 1 to 31 fixed, 0 unused
// - node id -1 follows select bits plus one, 0 to 127 fixed
`timescale 1ns/1ps
`default_nettype none
`include "dif_defines.svh"
module dif_input_logic #(
    parameter int LOAD_W = 32
) (
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    input wire dif_pkg::dif_inputs_t PINS_IN,
    input wire logic ALARM_RAISE_IN,
    input wire logic ALARM_FATAL_IN,
    input wire logic NOTICE_RAISE_IN,
    input wire logic NOTICE_AUTO_CLEAR_IN,
    input wire logic LOAD_AUTO_CLEAR_IN,
    input wire logic [LOAD_W-1:0] LOAD_ADD_IN,
    input wire dif_pkg::dif_latches_t LATCH_SET_IN,
    input wire logic [1:0] TOOL_ASSIGN_IN,
    input wire logic [1:0] ETO_MODE_IN,
    input wire logic TORQUE_OFF_ENTER_IN,
    input wire logic [13:0] TORQUE_LIMIT_IN,
    input wire logic SPEED_TYPE_IN,
    input wire logic [6:0] SPEED_RATIO_IN,
    input wire logic [21:0] SPEED_VALUE_IN,
    input wire logic MOTOR_STOPPED_IN,
    input wire logic [1:0] TUNE_MODE_IN,
    input wire logic COMM_RESET_IN,
    input wire logic [7:0] SLAVE_ADDR_SET_IN,
    input wire logic [7:0] NODE_ID_SET_IN,
    output logic ALARM_ACTIVE_OUT,
    output logic ALARM_FATAL_OUT,
    output logic NOTICE_OUT,
    output dif_pkg::dif_latches_t LATCH_OUT,
    output logic [LOAD_W-1:0] LOAD_OUT,
    output dif_pkg::dif_state_t DRIVE_STATE_OUT,
    output logic EXCITE_OUT,
    output logic TOOL_UNLOCKED_OUT,
    output logic [13:0] TORQUE_CAP_OUT,
    output logic SPEED_CAP_ON_OUT,
    output logic SPEED_CAP_MODE_OUT,
    output logic [21:0] SPEED_CAP_VAL_OUT,
    output logic POS_LOOP_ON_OUT,
    output logic AUTO_TUNE_ON_OUT,
    output logic AUTO_TUNE_MONITOR_OUT,
    output logic [7:0] SLAVE_ADDR_OUT,
    output logic [7:0] NODE_ID_OUT
);
    localparam int PW = $bits(dif_pkg::dif_inputs_t);

    // the load accumulator is only sized for 8 to 64 bits
    if (LOAD_W < 8 || LOAD_W > 64) begin : g_load_w_bad
        $error("LOAD_W out of range");
    end

    function automatic logic rising(input logic now, input logic was);
        rising = now & ~was;
    endfunction

    function automatic logic [7:0] pick_addr(input logic [7:0] set,
                                             input logic [7:0] max,
                                             input logic [7:0] follow,
                                             input logic [7:0] keep);
        if (set == `DIF_ADDR_FOLLOW) begin
            pick_addr = follow;
        end else if (set <= max) begin
            pick_addr = set;
        end else begin
            pick_addr = keep;
        end
    endfunction

    // synchroniser: stage a is read only by stage b
    logic [PW-1:0] sync_a_q;
    logic [PW-1:0] sync_b_q;
    logic [PW-1:0] prev_q;
    dif_pkg::dif_inputs_t in_s;
    dif_pkg::dif_inputs_t in_p;

    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            sync_a_q <= '0;
            sync_b_q <= '0;
            prev_q <= '0;
        end else begin
            sync_a_q <= PINS_IN;
            sync_b_q <= sync_a_q;
            prev_q <= sync_b_q;
        end
    end

    assign in_s = dif_pkg::dif_inputs_t'(sync_b_q);
    assign in_p = dif_pkg::dif_inputs_t'(prev_q);

    logic fault_edge;
    logic release_edge;
    logic release_hit;
    logic wipe_edge;
    logic notice_edge;
    assign fault_edge = rising(in_s.fault_clear, in_p.fault_clear);
    assign release_edge = rising(in_s.torque_off_release,
                                 in_p.torque_off_release);
    assign wipe_edge = rising(in_s.latch_wipe, in_p.latch_wipe);
    assign notice_edge = rising(in_s.notice_clear, in_p.notice_clear);
    assign release_hit = (ETO_MODE_IN == `DIF_ETO_LEVEL) ?
                         in_s.torque_off_release : release_edge;

    // status group: alarm, notice, latches, cumulative load
    logic alarm_q, alarm_d, fatal_q, fatal_d, notice_q, notice_d;
    dif_pkg::dif_latches_t lat_q, lat_d;
    logic [LOAD_W-1:0] load_q, load_d;

    always_comb begin
        alarm_d = alarm_q;
        fatal_d = fatal_q;
        if (fault_edge && !fatal_q) begin
            alarm_d = 1'b0;
        end
        // raise wins over a simultaneous clear
        if (ALARM_RAISE_IN) begin
            alarm_d = 1'b1;
            fatal_d = fatal_q | ALARM_FATAL_IN;
        end
        notice_d = notice_q;
        if (notice_edge && !NOTICE_AUTO_CLEAR_IN) begin
            notice_d = 1'b0;
        end
        notice_d = notice_d | NOTICE_RAISE_IN;
        lat_d = lat_q;
        if (wipe_edge) begin
            lat_d = '0;
        end
        lat_d = lat_d | LATCH_SET_IN;
        load_d = load_q;
        if (wipe_edge && !LOAD_AUTO_CLEAR_IN) begin
            load_d = '0;
        end
        load_d = LOAD_W'(load_d + LOAD_ADD_IN);
    end

    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            alarm_q <= 1'b0;
            fatal_q <= 1'b0;
            notice_q <= 1'b0;
            lat_q <= '0;
            load_q <= '0;
        end else begin
            alarm_q <= alarm_d;
            fatal_q <= fatal_d;
            notice_q <= notice_d;
            lat_q <= lat_d;
            load_q <= load_d;
        end
    end

    // drive state machine
    dif_pkg::dif_state_t st_q, st_d;
    logic safe_ok;
    assign safe_ok = in_s.safe_off_a & in_s.safe_off_b;

    always_comb begin
        st_d = st_q;
        case (st_q)
            dif_pkg::DIF_FREE: begin
                if (alarm_q) begin
                    st_d = dif_pkg::DIF_ALARM;
                end else if (!safe_ok || TORQUE_OFF_ENTER_IN) begin
                    st_d = dif_pkg::DIF_TORQUE_OFF;
                end else if (in_s.excite_request) begin
                    st_d = dif_pkg::DIF_EXCITED;
                end
            end
            dif_pkg::DIF_ALARM: begin
                if (!alarm_q) begin
                    st_d = dif_pkg::DIF_FREE;
                end
            end
            dif_pkg::DIF_TORQUE_OFF: begin
                if (alarm_q) begin
                    st_d = dif_pkg::DIF_ALARM;
                end else if (safe_ok && release_hit) begin
                    st_d = in_s.excite_request ? dif_pkg::DIF_EXCITED :
                           dif_pkg::DIF_FREE;
                end
            end
            dif_pkg::DIF_EXCITED: begin
                if (alarm_q) begin
                    st_d = dif_pkg::DIF_ALARM;
                end else if (!safe_ok || TORQUE_OFF_ENTER_IN) begin
                    st_d = dif_pkg::DIF_TORQUE_OFF;
                end else if (!in_s.excite_request) begin
                    st_d = dif_pkg::DIF_FREE;
                end
            end
            default: st_d = dif_pkg::DIF_FREE;
        endcase
    end

    // function change group
    logic tool_d, tcap_on_d, scap_on_d, smode_d, ploop_d, tune_d, mon_d;
    logic [13:0] tcap_d;
    logic [21:0] sval_d;

    always_comb begin
        case (TOOL_ASSIGN_IN)
            2'h0: tool_d = 1'b1;
            2'h1: tool_d = in_s.tool_direct;
            2'h2: tool_d = in_s.tool_remote;
            default: tool_d = in_s.tool_direct & in_s.tool_remote;
        endcase
        tcap_on_d = in_s.torque_cap;
        tcap_d = (TORQUE_LIMIT_IN > `DIF_TRQ_MAX) ? `DIF_TRQ_MAX :
                 TORQUE_LIMIT_IN;
        if (!tcap_on_d) begin
            tcap_d = `DIF_TORQUE_NONE;
        end
        scap_on_d = in_s.velocity_cap;
        smode_d = SPEED_TYPE_IN;
        if (SPEED_TYPE_IN == `DIF_SPD_RATIO) begin
            if (SPEED_RATIO_IN < `DIF_RATIO_MIN) begin
                sval_d = 22'(`DIF_RATIO_MIN);
            end else if (SPEED_RATIO_IN > `DIF_RATIO_MAX) begin
                sval_d = 22'(`DIF_RATIO_MAX);
            end else begin
                sval_d = 22'(SPEED_RATIO_IN);
            end
        end else begin
            if (SPEED_VALUE_IN < `DIF_VEL_MIN) begin
                sval_d = `DIF_VEL_MIN;
            end else if (SPEED_VALUE_IN > `DIF_VEL_MAX) begin
                sval_d = `DIF_VEL_MAX;
            end else begin
                sval_d = SPEED_VALUE_IN;
            end
        end
        // loop choice only matters at standstill; keep last value in motion
        ploop_d = MOTOR_STOPPED_IN ? in_s.hold_loop_select :
                  POS_LOOP_ON_OUT;
        case (TUNE_MODE_IN)
            2'h1: tune_d = in_s.auto_tune_enable;
            2'h2: tune_d = 1'b1;
            default: tune_d = 1'b0;
        endcase
        mon_d = tune_d;
    end

    // address group
    logic [7:0] slave_d, node_d, follow;
    logic take_q, take_d;
    assign follow = {4'h0, in_s.node_select_bits} + 8'h01;

    always_comb begin
        take_d = 1'b0;
        slave_d = SLAVE_ADDR_OUT;
        node_d = NODE_ID_OUT;
        // take addresses at the first edge after reset, while sync stage b still holds its reset zeros
        if (take_q || COMM_RESET_IN) begin
            slave_d = pick_addr(SLAVE_ADDR_SET_IN, `DIF_SLAVE_MAX, follow,
                                SLAVE_ADDR_OUT);
            if (SLAVE_ADDR_SET_IN == 8'h00) begin
                slave_d = SLAVE_ADDR_OUT;
            end
            node_d = pick_addr(NODE_ID_SET_IN, `DIF_NODE_MAX, follow,
                               NODE_ID_OUT);
        end
    end

    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            st_q <= dif_pkg::DIF_FREE;
            TOOL_UNLOCKED_OUT <= 1'b0;
            TORQUE_CAP_OUT <= `DIF_TORQUE_NONE;
            SPEED_CAP_ON_OUT <= 1'b0;
            SPEED_CAP_MODE_OUT <= `DIF_SPD_RATIO;
            SPEED_CAP_VAL_OUT <= 22'(`DIF_RATIO_RST);
            POS_LOOP_ON_OUT <= 1'b0;
            AUTO_TUNE_ON_OUT <= 1'b0;
            AUTO_TUNE_MONITOR_OUT <= 1'b0;
            SLAVE_ADDR_OUT <= 8'h01;
            NODE_ID_OUT <= 8'h01;
            take_q <= 1'b1;
        end else begin
            st_q <= st_d;
            TOOL_UNLOCKED_OUT <= tool_d;
            TORQUE_CAP_OUT <= tcap_d;
            SPEED_CAP_ON_OUT <= scap_on_d;
            SPEED_CAP_MODE_OUT <= smode_d;
            SPEED_CAP_VAL_OUT <= sval_d;
            POS_LOOP_ON_OUT <= ploop_d;
            AUTO_TUNE_ON_OUT <= tune_d;
            AUTO_TUNE_MONITOR_OUT <= mon_d;
            SLAVE_ADDR_OUT <= slave_d;
            NODE_ID_OUT <= node_d;
            take_q <= take_d;
        end
    end

    assign ALARM_ACTIVE_OUT = alarm_q;
    assign ALARM_FATAL_OUT = fatal_q;
    assign NOTICE_OUT = notice_q;
    assign LATCH_OUT = lat_q;
    assign LOAD_OUT = load_q;
    assign DRIVE_STATE_OUT = st_q;
    assign EXCITE_OUT = (st_q == dif_pkg::DIF_EXCITED);
endmodule
`default_nettype wire

// ---- verilog/dif_pkg.sv ----
// types for the driver input function logic
package dif_pkg;
    typedef enum logic [1:0] {
        DIF_FREE = 2'b00,
        DIF_ALARM = 2'b01,
        DIF_TORQUE_OFF = 2'b10,
        DIF_EXCITED = 2'b11
    } dif_state_t;

    typedef struct packed {
        logic fault_clear;
        logic torque_off_release;
        logic latch_wipe;
        logic notice_clear;
        logic tool_direct;
        logic tool_remote;
        logic torque_cap;
        logic velocity_cap;
        logic hold_loop_select;
        logic auto_tune_enable;
        logic safe_off_a;
        logic safe_off_b;
        logic excite_request;
        logic [3:0] node_select_bits;
    } dif_inputs_t;

    typedef struct packed {
        logic user_capture_0;
        logic user_capture_1;
        logic step_capture_flag;
        logic branch_capture_low;
        logic branch_capture_mid;
        logic branch_capture_high;
        logic stop_capture;
        logic [7:0] branch_event_low;
        logic [7:0] branch_event_mid;
        logic [7:0] branch_event_high;
    } dif_latches_t;
endpackage
